// >>> core/osr_pkg.sv
// security register and power-up gating constants
// assumes a 250 MHz core clock sampling the serial link pins
package osr_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CMD_W = 8;
  localparam logic [7:0] OP_WRITE_SEC = 8'h2f;
  localparam logic [7:0] OP_READ_SEC = 8'h2b;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_PAGE_WR = 8'h02;
  localparam logic [7:0] OP_SECT_CLR = 8'h20;
  localparam logic [7:0] OP_BLOCK_CLR = 8'hd8;
  localparam logic [7:0] OP_ARRAY_CLR = 8'h60;
  localparam logic [7:0] OP_ARRAY_CLR2 = 8'hc7;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_CPM_ENTER = 8'had;
  localparam int unsigned BIT_FACTORY = 0;
  localparam int unsigned BIT_LOCK = 1;
  localparam int unsigned BIT_CPM = 4;
  localparam logic [7:0] SEC_RESET = 8'h00;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  // delays in microseconds
  localparam int unsigned SEL_READY_US = 10;
  localparam int unsigned WR_READY_US = 100;
  localparam int unsigned SEL_READY_CYC = SEL_READY_US * CLK_MHZ;
  localparam int unsigned WR_READY_CYC = WR_READY_US * CLK_MHZ;
  localparam int unsigned DLY_W = 32;
  typedef enum logic [1:0] {
    OSR_IDLE  = 2'b00,
    OSR_CMD   = 2'b01,
    OSR_OUT   = 2'b10,
    OSR_WAIT  = 2'b11
  } osr_state_e;
endpackage

// >>> core/osr_security_reg.sv
// security register, opcode decode and power-up command gating
// assumes link pins are asynchronous and sampled by clk; srst is the power-on clear
`timescale 1ns/1ps
// How it works
// - bit1 is the lock-down flag; one forbids changing the secured area.
// - write-security command needs no prior write latch set.
// - write-security command sets bit1, locking the secured area.
// - once locked, every secured area update is refused.
// - write-security runs only when select rises on a byte boundary.
// - power-up lands in standby, never deep power-down.
// - power-up clears the write latch.
// - below threshold the logic is held reset and commands are ignored.
// - write-class commands wait for the write-ready delay.
// - reads are accepted after the select-ready delay alone.
// - on power-down all operations stop and commands are ignored.
// - bit4 reads one while in continuous program mode.
// - bit0 reads one when the area was locked at the factory.
// - security register read is served any time after the select-ready delay, repeatedly.
module osr_security_reg
  import osr_pkg::*;
#(
  parameter int unsigned SEL_READY_CYCLES = SEL_READY_CYC,
  parameter int unsigned WR_READY_CYCLES  = WR_READY_CYC
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic factory_locked,
  input  wire logic cpm_active,
  output logic      so_out,
  output logic      so_oe_n,
  output logic      write_latch_flag,
  output logic      deep_pd,
  output logic      otp_locked,
  output logic      write_ready,
  output logic      read_ready,
  output logic [7:0] sec_status
);

  logic [2:0] sclk_sync_reg;
  logic [2:0] cs_sync_reg;
  logic [2:0] si_sync_reg;
  logic       sclk_lvl_reg;
  logic       cs_lvl_reg;
  logic       si_lvl_reg;
  logic       factory_reg;
  logic       otp_lockdown_bit_reg;
  logic       wel_reg;
  logic [DLY_W-1:0] dly_cnt_reg;
  logic       rd_ok_reg;
  logic       wr_ok_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic       byte_done_reg;
  logic [7:0] opcode_reg;
  logic [7:0] out_reg;
  logic       so_reg;
  logic       so_oe_n_reg;
  osr_state_e state_reg;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic [7:0] sec_view;

  function automatic logic is_write_class(input logic [7:0] op);
    return op == OP_LATCH_SET || op == OP_PAGE_WR || op == OP_CPM_ENTER ||
           op == OP_SECT_CLR || op == OP_BLOCK_CLR || op == OP_ARRAY_CLR ||
           op == OP_ARRAY_CLR2 || op == OP_WRITE_SEC || op == OP_STAT_WR;
  endfunction

  // a change counts once the second and third stages agree
  always_ff @(posedge clk) begin
    sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
    cs_sync_reg   <= {cs_sync_reg[1:0], cs_n};
    si_sync_reg   <= {si_sync_reg[1:0], si};
    if (srst) begin
      sclk_lvl_reg <= 1'b0;
      cs_lvl_reg   <= 1'b1;
      si_lvl_reg   <= 1'b0;
    end else begin
      if (sclk_sync_reg[1] == sclk_sync_reg[2]) sclk_lvl_reg <= sclk_sync_reg[2];
      if (cs_sync_reg[1] == cs_sync_reg[2]) cs_lvl_reg <= cs_sync_reg[2];
      if (si_sync_reg[1] == si_sync_reg[2]) si_lvl_reg <= si_sync_reg[2];
    end
  end

  assign sclk_rise = sclk_sync_reg[1] && sclk_sync_reg[2] && !sclk_lvl_reg;
  assign sclk_fall = !sclk_sync_reg[1] && !sclk_sync_reg[2] && sclk_lvl_reg;
  assign cs_fall   = !cs_sync_reg[1] && !cs_sync_reg[2] && cs_lvl_reg;
  assign cs_rise   = cs_sync_reg[1] && cs_sync_reg[2] && !cs_lvl_reg;

  // power-up delays counted from release of the power-on clear
  always_ff @(posedge clk) begin
    if (srst) begin
      dly_cnt_reg <= '0;
      rd_ok_reg   <= 1'b0;
      wr_ok_reg   <= 1'b0;
    end else begin
      if (!wr_ok_reg) dly_cnt_reg <= dly_cnt_reg + 1'b1;
      if (dly_cnt_reg >= DLY_W'(SEL_READY_CYCLES)) rd_ok_reg <= 1'b1;
      if (dly_cnt_reg >= DLY_W'(WR_READY_CYCLES)) wr_ok_reg <= 1'b1;
    end
  end

  // factory indicator is caught after the release, never by the reset itself
  always_ff @(posedge clk) begin
    if (srst) factory_reg <= 1'b0;
    else factory_reg <= factory_locked;
  end

  // opcode shifter; a byte completes on the eighth rising edge
  always_ff @(posedge clk) begin
    if (srst || cs_lvl_reg) begin
      shift_reg     <= '0;
      bit_cnt_reg   <= '0;
      byte_done_reg <= 1'b0;
    end else if (sclk_rise) begin
      shift_reg     <= {shift_reg[6:0], si_lvl_reg};
      bit_cnt_reg   <= bit_cnt_reg + 1'b1;
      byte_done_reg <= (bit_cnt_reg == BIT_CNT_LAST);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg  <= OSR_IDLE;
      opcode_reg <= '0;
    end else begin
      unique case (state_reg)
        OSR_IDLE: if (cs_fall && rd_ok_reg) state_reg <= OSR_CMD;
        OSR_CMD: begin
          if (cs_rise) state_reg <= OSR_IDLE;
          else if (sclk_rise && bit_cnt_reg == BIT_CNT_LAST) begin
            opcode_reg <= {shift_reg[6:0], si_lvl_reg};
            state_reg  <= ({shift_reg[6:0], si_lvl_reg} == OP_READ_SEC) ? OSR_OUT : OSR_WAIT;
          end
        end
        OSR_OUT: if (cs_rise) state_reg <= OSR_IDLE;
        OSR_WAIT: if (cs_rise) state_reg <= OSR_IDLE;
      endcase
    end
  end

  // select rising right after a whole opcode byte executes it
  logic exec_ok;
  assign exec_ok = state_reg == OSR_WAIT && cs_rise && byte_done_reg &&
                   (!is_write_class(opcode_reg) || wr_ok_reg);

  always_ff @(posedge clk) begin
    if (srst) begin
      otp_lockdown_bit_reg <= 1'b0;
      wel_reg              <= 1'b0;
    end else if (exec_ok) begin
      // no latch check: the lock write is free-standing
      if (opcode_reg == OP_WRITE_SEC) otp_lockdown_bit_reg <= 1'b1;
      if (opcode_reg == OP_LATCH_SET) wel_reg <= 1'b1;
      if (opcode_reg == OP_LATCH_CLR) wel_reg <= 1'b0;
    end
  end

  // reserved positions keep the reset pattern, so no write can reach them
  always_comb begin
    sec_view               = SEC_RESET;
    sec_view[BIT_FACTORY]  = factory_reg;
    sec_view[BIT_LOCK]     = otp_lockdown_bit_reg;
    sec_view[BIT_CPM]      = cpm_active;
  end

  // read data launched on falling edges, repeating every eight bits
  always_ff @(posedge clk) begin
    if (srst) begin
      out_reg     <= SEC_RESET;
      so_reg      <= 1'b0;
      so_oe_n_reg <= 1'b1;
    end else if (state_reg == OSR_OUT && !cs_rise) begin
      so_oe_n_reg <= 1'b0;
      if (sclk_fall) begin
        if (bit_cnt_reg == '0) begin
          so_reg  <= sec_view[7];
          out_reg <= {sec_view[6:0], 1'b0};
        end else begin
          so_reg  <= out_reg[7];
          out_reg <= {out_reg[6:0], 1'b0};
        end
      end
    end else begin
      so_oe_n_reg <= 1'b1;
      so_reg      <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sec_status  <= SEC_RESET;
      write_ready <= 1'b0;
      read_ready  <= 1'b0;
      deep_pd     <= 1'b0;
      otp_locked  <= 1'b0;
    end else begin
      sec_status  <= sec_view;
      write_ready <= wr_ok_reg;
      read_ready  <= rd_ok_reg;
      deep_pd     <= 1'b0;
      otp_locked  <= otp_lockdown_bit_reg;
    end
  end

  assign so_out           = so_reg;
  assign so_oe_n          = so_oe_n_reg;
  assign write_latch_flag = wel_reg;

  a_lock_sticky: assert property (@(posedge clk) disable iff (srst)
    $past(otp_lockdown_bit_reg) |-> otp_lockdown_bit_reg)
    else $error("lock bit cleared");
  a_lock_cause: assert property (@(posedge clk) disable iff (srst)
    $rose(otp_lockdown_bit_reg) |-> $past(exec_ok && opcode_reg == OP_WRITE_SEC))
    else $error("lock set without command");
  a_boundary_only: assert property (@(posedge clk) disable iff (srst)
    $rose(otp_lockdown_bit_reg) |-> $past(byte_done_reg))
    else $error("lock set off byte boundary");
  a_write_gate: assert property (@(posedge clk) disable iff (srst)
    $rose(wel_reg) |-> $past(wr_ok_reg))
    else $error("write class before delay");
  a_read_gate: assert property (@(posedge clk) disable iff (srst)
    (state_reg == OSR_IDLE && !rd_ok_reg) |=> state_reg == OSR_IDLE)
    else $error("selected before ready");
  a_reserved_zero: assert property (@(posedge clk) disable iff (srst)
    sec_status[7:5] == 3'h0 && sec_status[3:2] == 2'h0)
    else $error("reserved bit set");
  a_lock_mirror: assert property (@(posedge clk) disable iff (srst)
    otp_lockdown_bit_reg |=> otp_locked)
    else $error("lock flag not shown");
  // last opcode bit arrives and completes the read opcode
  sequence s_read_opcode;
    state_reg == OSR_CMD && sclk_rise && bit_cnt_reg == BIT_CNT_LAST &&
      {shift_reg[6:0], si_lvl_reg} == OP_READ_SEC;
  endsequence
  sequence s_still_selected;
    !cs_rise;
  endsequence
  a_read_drive: assert property (@(posedge clk) disable iff (srst)
    s_read_opcode ##1 s_still_selected |=> !so_oe_n_reg)
    else $error("read opcode not answered");
  a_reset_clears: assert property (@(posedge clk)
    srst |=> !wel_reg && !deep_pd && !rd_ok_reg)
    else $error("power-up state wrong");

endmodule // osr_security_reg

// >>> bench/osr_host_model.sv
// host serial controller model driving the link pins of the register block
// assumes frames are started on a falling clk edge; sclk half period 40 ns
`timescale 1ns/1ps
module osr_host_model (
  input  wire logic so_out,
  input  wire logic so_oe_n,
  output logic      sclk,
  output logic      cs_n,
  output logic      si
);
  logic [15:0] rdata;
  logic        oe_seen;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // opcode bits then optional read bits; sclk stands low outside frames
  task automatic xfer(input logic [7:0] op, input int nb, input int nrd);
    int i;
    oe_seen = 1'b0;
    cs_n = 1'b0;
    for (i = 0; i < nb + nrd; i++) begin
      si = (i < 8) ? op[7 - i] : ~si;
      #40;
      if (i >= nb) rdata = {rdata[14:0], so_out};
      oe_seen = oe_seen | ~so_oe_n;
      sclk = 1'b1;
      #40;
      sclk = 1'b0;
    end
    #40;
    cs_n = 1'b1;
    // released line must not keep a stale level
    si = ~si;
    // deselect gap, so a following frame shows a real select rise and fall
    #80;
  endtask
endmodule // osr_host_model

// >>> bench/osr_security_reg_test.sv
// self-checking bench for the security register and power-up gating
// assumes the host model drives the link; power-up delays shortened
`timescale 1ns/1ps
module osr_security_reg_test;
  import osr_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic [3:0] nb;
    logic       rd;
    logic       fl;
    logic       cp;
    logic       lk;
    logic       wl;
  } osr_row_s;
  logic       clk, srst, factory_locked, cpm_active, sclk, cs_n, si, so_out, so_oe_n;
  logic       write_latch_flag, deep_pd, otp_locked, write_ready, read_ready;
  logic [7:0] sec_status;
  logic [7:0] ex;
  int         mismatches, cmp_count, r;
  osr_row_s   rows [9] = '{
    '{8'h2f, 4'h9, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}, '{8'h2f, 4'h7, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
    '{8'h06, 4'h8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1}, '{8'h04, 4'h8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
    '{8'h2b, 4'h8, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0}, '{8'h2f, 4'h8, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
    '{8'h2b, 4'h8, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0}, '{8'h2f, 4'h8, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0},
    '{8'h06, 4'h8, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1}};
  osr_host_model host (.so_out(so_out), .so_oe_n(so_oe_n), .sclk(sclk), .cs_n(cs_n), .si(si));
  osr_security_reg #(.SEL_READY_CYCLES(20), .WR_READY_CYCLES(1000)) DUT (
    .clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .si(si),
    .factory_locked(factory_locked), .cpm_active(cpm_active), .so_out(so_out),
    .so_oe_n(so_oe_n), .write_latch_flag(write_latch_flag), .deep_pd(deep_pd),
    .otp_locked(otp_locked), .write_ready(write_ready), .read_ready(read_ready),
    .sec_status(sec_status));
  always #2 clk = ~clk;
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #60us;
    mismatches++;
    give_verdict();
  end
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    factory_locked = 1'b1;
    cpm_active = 1'b1;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    while (!write_ready) @(negedge clk);
    for (r = 0; r < 9; r++) begin
      factory_locked = rows[r].fl;
      cpm_active = rows[r].cp;
      host.xfer(rows[r].op, int'(rows[r].nb), rows[r].rd ? 16 : 0);
      repeat (10) @(negedge clk);
      ex = {3'h0, rows[r].cp, 2'h0, rows[r].lk, rows[r].fl};
      chk("flags", {13'h0, rows[r].lk, rows[r].wl, 1'b0}, {13'h0, otp_locked, write_latch_flag, deep_pd});
      chk("status", {8'h00, ex}, {8'h00, sec_status});
      if (rows[r].rd) chk("read", {ex, ex}, host.rdata);
    end
    // power dip in mid-run clears the volatile state and restarts the delays
    srst = 1'b1;
    factory_locked = 1'b1;
    cpm_active = 1'b1;
    repeat (5) @(negedge clk);
    chk("reset outs", 16'h0001, {sec_status, write_latch_flag, deep_pd, so_oe_n});
    srst = 1'b0;
    @(negedge clk);
    chk("after dip", 16'h0000, {12'h0, otp_locked, write_latch_flag, deep_pd, read_ready});
    // select before the select delay: whole frame ignored
    host.xfer(8'h2b, 8, 16);
    chk("early oe", 16'h0000, {15'h0, host.oe_seen});
    chk("ready", 16'h0002, {14'h0, read_ready, write_ready});
    host.xfer(8'h2f, 8, 0);
    repeat (10) @(negedge clk);
    chk("early lock", 16'h0000, {15'h0, otp_locked});
    host.xfer(8'h06, 8, 0);
    repeat (10) @(negedge clk);
    chk("early latch", 16'h0000, {15'h0, write_latch_flag});
    host.xfer(8'h2b, 8, 16);
    chk("early read", 16'h1111, host.rdata);
    chk("write ready", 16'h0001, {15'h0, write_ready});
    give_verdict();
  end
endmodule // osr_security_reg_test
